// [hsss_map.vh]
// Constants for the sample and sleep sequencer
`ifndef HSSS_MAP_VH
`define HSSS_MAP_VH
// ****************************************
// Timing
// ****************************************
`define HSSS_CLK_PERIOD_NS   25
`define HSSS_TICK_NS         10000
`define HSSS_TICK_CYC        (`HSSS_TICK_NS / `HSSS_CLK_PERIOD_NS)
`define HSSS_TICK_CNT_W      9
`define HSSS_EN_MIN_TICKS    2
`define HSSS_AWAKE_TICKS     12
`define HSSS_PULSE_TICKS     14
`define HSSS_AUTO_TICKS      16
`define HSSS_PH_CNT_W        5
`define HSSS_CODE_W          8
// ****************************************
// States
// ****************************************
`define HSSS_ST_SLEEP        2'h0
`define HSSS_ST_AWAKE        2'h1
`define HSSS_ST_REST         2'h2
`endif

// [hsss_sequencer.v]
// Sample and sleep sequencer for a linear field sensor
// Contract
// (RL1) All phases are timed in whole ticks of a free-running 10 us tick.
// (RL2) Controller holds wake high at least two ticks to start a sample.
// (RL3) After trigger the awake phase lasts twelve ticks.
// (RL4) Pulsed cycle spans fourteen ticks; controller pulses no faster.
// (RL5) Wake held high samples repeatedly, sixteen ticks per cycle.
// (RL6) During sleep the output holds the last completed conversion.
// (RL7) Output becomes valid one sample cycle after wake first goes high.
// (RL8) Wake low keeps the device asleep with no new conversions.
// (RL9) Each conversion yields an 8-bit output code.
// (RL10) Wake rise is sampled on the tick before counting the awake phase.
`timescale 1ns/100ps
`include "hsss_map.vh"
module hsss_sequencer #(
    parameter CODE_W   = `HSSS_CODE_W,
    parameter TICK_CYC = `HSSS_TICK_CYC
) (
    input  wire              clk_sys_i,
    input  wire              rstn_i,
    input  wire              wake_i,
    input  wire [CODE_W-1:0] adc_code_i,
    output reg  [CODE_W-1:0] dac_code_o,
    output reg               out_valid_o,
    output reg               awake_o,
    output reg               sample_o
);
// ****************************************
// Reset release
// ****************************************
reg rst_meta_r;
reg rst_sync_r;
always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
        rst_meta_r <= 1'b0;
        rst_sync_r <= 1'b0;
    end else begin
        rst_meta_r <= 1'b1;
        rst_sync_r <= rst_meta_r;
    end
end
// ****************************************
// Internal tick
// ****************************************
reg [`HSSS_TICK_CNT_W-1:0]  tick_cnt_r;
reg [`HSSS_TICK_CNT_W-1:0]  tick_cnt_nxt;
reg                         tick_r;
reg                         tick_nxt;
wire [`HSSS_TICK_CNT_W-1:0] tick_last = TICK_CYC[`HSSS_TICK_CNT_W-1:0] - 9'h001;

always @* begin
    if (tick_cnt_r == tick_last) begin
        tick_cnt_nxt = {`HSSS_TICK_CNT_W{1'b0}}; // [RL1]
        tick_nxt     = 1'b1;
    end else begin
        tick_cnt_nxt = tick_cnt_r + 9'h001;
        tick_nxt     = 1'b0;
    end
end

always @(posedge clk_sys_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
        tick_cnt_r <= {`HSSS_TICK_CNT_W{1'b0}};
        tick_r     <= 1'b0;
    end else begin
        tick_cnt_r <= tick_cnt_nxt;
        tick_r     <= tick_nxt;
    end
end

// ****************************************
// Wake sampling
// ****************************************
reg                      wake_tk_r;
reg                      wake_tk_nxt;
reg [`HSSS_PH_CNT_W-1:0] hi_ticks_r;
reg [`HSSS_PH_CNT_W-1:0] hi_ticks_nxt;

always @* begin
    wake_tk_nxt  = wake_tk_r;
    hi_ticks_nxt = hi_ticks_r;
    if (tick_r) begin
        wake_tk_nxt = wake_i; // [RL10]
        if (!wake_i)
            hi_ticks_nxt = 5'h00;
        else if (hi_ticks_r != 5'h1F)
            hi_ticks_nxt = hi_ticks_r + 5'h01;
    end
end

always @(posedge clk_sys_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
        wake_tk_r  <= 1'b0;
        hi_ticks_r <= 5'h00;
    end else begin
        wake_tk_r  <= wake_tk_nxt;
        hi_ticks_r <= hi_ticks_nxt;
    end
end

// Wake high for the least pulse width, seen on the tick
wire wake_ok = wake_i && (hi_ticks_r >= `HSSS_EN_MIN_TICKS - 1); // [RL2] [RL10]

// ****************************************
// Phase sequencer, next state
// ****************************************
reg [1:0]                state_r;
reg [1:0]                state_nxt;
reg [`HSSS_PH_CNT_W-1:0] ph_cnt_r;
reg [`HSSS_PH_CNT_W-1:0] ph_cnt_nxt;
reg                      auto_r;
reg                      auto_nxt;
reg [CODE_W-1:0]         code_nxt;
reg                      valid_nxt;
reg                      awake_nxt;
reg                      sample_nxt;

always @* begin
    state_nxt  = state_r;
    ph_cnt_nxt = ph_cnt_r;
    auto_nxt   = auto_r;
    code_nxt   = dac_code_o;
    valid_nxt  = out_valid_o;
    awake_nxt  = awake_o;
    sample_nxt = 1'b0;
    if (tick_r) begin
        case (state_r)
            `HSSS_ST_SLEEP: begin
                if (wake_ok && wake_tk_r) begin // [RL8]
                    state_nxt  = `HSSS_ST_AWAKE;
                    ph_cnt_nxt = 5'h01;
                    auto_nxt   = 1'b0;
                    awake_nxt  = 1'b1;
                end
            end
            `HSSS_ST_AWAKE: begin
                if (!wake_i)
                    auto_nxt = 1'b0;
                else if (ph_cnt_r == 5'h01)
                    auto_nxt = 1'b1;
                ph_cnt_nxt = ph_cnt_r + 5'h01;
                if (ph_cnt_r == `HSSS_AWAKE_TICKS) begin // [RL3]
                    code_nxt   = adc_code_i; // [RL9]
                    sample_nxt = 1'b1;
                    valid_nxt  = 1'b1; // [RL7]
                    awake_nxt  = 1'b0;
                    state_nxt  = `HSSS_ST_REST;
                end
            end
            `HSSS_ST_REST: begin
                // Auto-run holds wake high the whole cycle
                if (wake_i && auto_r) begin
                    if (ph_cnt_r == `HSSS_AUTO_TICKS) begin // [RL5]
                        state_nxt  = `HSSS_ST_AWAKE;
                        ph_cnt_nxt = 5'h01;
                        awake_nxt  = 1'b1;
                    end else begin
                        ph_cnt_nxt = ph_cnt_r + 5'h01;
                    end
                end else if (ph_cnt_r >= `HSSS_PULSE_TICKS) begin // [RL4]
                    state_nxt  = `HSSS_ST_SLEEP;
                    ph_cnt_nxt = 5'h00;
                    auto_nxt   = 1'b0;
                end else begin
                    auto_nxt   = 1'b0;
                    ph_cnt_nxt = ph_cnt_r + 5'h01;
                end
            end
            default: begin
                state_nxt = `HSSS_ST_SLEEP;
                awake_nxt = 1'b0;
            end
        endcase
    end
end

// ****************************************
// Phase sequencer, registers
// ****************************************
// Output code changes only at end of conversion, held through sleep [RL6]
always @(posedge clk_sys_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
        state_r     <= `HSSS_ST_SLEEP;
        ph_cnt_r    <= 5'h00;
        auto_r      <= 1'b0;
        dac_code_o  <= {CODE_W{1'b0}};
        out_valid_o <= 1'b0;
        awake_o     <= 1'b0;
        sample_o    <= 1'b0;
    end else begin
        state_r     <= state_nxt;
        ph_cnt_r    <= ph_cnt_nxt;
        auto_r      <= auto_nxt;
        dac_code_o  <= code_nxt; // [RL6]
        out_valid_o <= valid_nxt;
        awake_o     <= awake_nxt;
        sample_o    <= sample_nxt;
    end
end

endmodule // hsss_sequencer

// [hsss_seq_monitor.sv]
// Checker for the sequencer ports
`timescale 1ns/100ps
module hsss_seq_monitor #(parameter CODE_W = 8, parameter TICK_CYC = 400) (
    input wire clk_sys_i, rstn_i, wake_i, out_valid_o, awake_o, sample_o,
    input wire [CODE_W-1:0] adc_code_i, dac_code_o);
reg [15:0] aw_r;
always @(posedge clk_sys_i or negedge rstn_i)
    if (!rstn_i) aw_r <= 16'h0000; else aw_r <= awake_o ? aw_r + 16'h0001 : 16'h0000;
default clocking @(posedge clk_sys_i); endclocking
default disable iff (!rstn_i);
a_aw_len: assert property (sample_o |-> aw_r == 12 * TICK_CYC) else $error("awake len");
a_aw_end: assert property (sample_o |-> !awake_o && $past(awake_o)) else $error("awake end");
a_smp_pulse: assert property (sample_o |=> !sample_o) else $error("sample pulse");
a_code_load: assert property (sample_o |-> dac_code_o == $past(adc_code_i)) else $error("load");
a_code_hold: assert property (!sample_o |-> $stable(dac_code_o)) else $error("hold");
a_val_rise: assert property ($rose(out_valid_o) |-> sample_o) else $error("valid rise");
a_val_keep: assert property (out_valid_o |=> out_valid_o) else $error("valid drop");
a_wake_start: assert property ($rose(awake_o) |-> $past(wake_i)) else $error("wake");
endmodule // hsss_seq_monitor

// [hsss_ctrl_model.sv]
// Controller model driving the wake pin
`timescale 1ns/100ps
module hsss_ctrl_model (
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic [15:0] len_i,
    output logic             wake_o);
logic [15:0] cnt_r = 16'h0000;
initial wake_o = 1'b0;
always @(posedge clk_i) begin
    if (go_i) begin
        cnt_r <= #1 len_i;
        wake_o <= #1 1'b1;
    end else if (cnt_r != 16'h0000) begin
        cnt_r <= #1 cnt_r - 16'h0001;
        wake_o <= #1 (cnt_r != 16'h0001);
    end
end
endmodule // hsss_ctrl_model

// [tb_top.sv]
// Testbench for the sequencer
`timescale 1ns/100ps
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin fails++; \
    $display("ERROR %s exp %0h got %0h", nm, e, a); end end
module tb_top;
localparam int T = 4;
logic clk_sys_i = 0, rstn_i = 0, go = 0;
logic [15:0] len = 16'h0000;
logic [7:0] adc_code_i = 8'h00, dac_code_o;
logic wake_i, out_valid_o, awake_o, sample_o;
int fails = 0, total_checks = 0, n, a;
always #12.5 clk_sys_i = ~clk_sys_i;
hsss_sequencer #(.TICK_CYC(T)) u_hsss_sequencer (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .wake_i(wake_i), .adc_code_i(adc_code_i), .dac_code_o(dac_code_o),
    .out_valid_o(out_valid_o), .awake_o(awake_o), .sample_o(sample_o));
hsss_ctrl_model u_hsss_ctrl_model (.clk_i(clk_sys_i), .go_i(go), .len_i(len), .wake_o(wake_i));
task automatic cyc(int k); repeat (k) @(posedge clk_sys_i); #1; endtask
task automatic send(int k); go = 1; len = k[15:0]; cyc(1); go = 0; endtask
task automatic wait_smp(output int c, output int w);
    c = 1; w = 0; cyc(1);
    while (sample_o !== 1'b1 && c < 100 * T) begin w += (awake_o === 1'b1); cyc(1); c++; end
endtask
task automatic t_short;
    send(T - 1); wait_smp(n, a);
    `CHK("awake", 0, a)
    `CHK("valid", 1'b0, out_valid_o)
    $display("t_short done");
endtask
task automatic t_pulse;
    adc_code_i = 8'hA5; send(3 * T); wait_smp(n, a);
    `CHK("awake_len", 12 * T, a)
    `CHK("code", 8'hA5, dac_code_o)
    `CHK("valid", 1'b1, out_valid_o)
    adc_code_i = 8'h3C; wait_smp(n, a);
    `CHK("idle", 0, a)
    `CHK("held", 8'hA5, dac_code_o)
    $display("t_pulse done");
endtask
task automatic t_auto;
    adc_code_i = 8'h5A; send(16'hFFFF); wait_smp(n, a);
    `CHK("code", 8'h5A, dac_code_o)
    adc_code_i = 8'hC3; wait_smp(n, a);
    `CHK("period", 16 * T, n)
    `CHK("code", 8'hC3, dac_code_o)
    send(1); cyc(20 * T);
    $display("t_auto done");
endtask
task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask
initial begin cyc(6); rstn_i = 1; cyc(4); t_short; t_pulse; t_auto; wrap_up; end
initial begin #(5000 * 25); fails++; wrap_up; end
endmodule // tb_top
bind hsss_sequencer hsss_seq_monitor #(.CODE_W(CODE_W), .TICK_CYC(TICK_CYC)) u_mon (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wake_i(wake_i), .out_valid_o(out_valid_o),
    .awake_o(awake_o), .sample_o(sample_o), .adc_code_i(adc_code_i), .dac_code_o(dac_code_o));
